// ==== src/cpf_pkg.sv ====
`default_nettype none
package cpf_pkg;
    // Clock and time figures
    localparam int CPF_CLK_MHZ = 100;
    localparam int CPF_T_HARD_SHORT_US = 1;
    localparam int CPF_T_HARD_LONG_US = 90;
    localparam int CPF_T_SOFT_SHORT_MS = 8;
    localparam int CPF_T_UV_RECOVER_MS = 20;
    localparam int CPF_T_RETRY_MS = 500;
    localparam int CPF_HARD_SHORT_CYC = CPF_T_HARD_SHORT_US * CPF_CLK_MHZ;
    localparam int CPF_HARD_LONG_CYC = CPF_T_HARD_LONG_US * CPF_CLK_MHZ;
    localparam int CPF_SOFT_SHORT_CYC = CPF_T_SOFT_SHORT_MS * 1000 * CPF_CLK_MHZ;
    localparam int CPF_UV_RECOVER_CYC = CPF_T_UV_RECOVER_MS * 1000 * CPF_CLK_MHZ;
    localparam int CPF_RETRY_CYC = CPF_T_RETRY_MS * 1000 * CPF_CLK_MHZ;
    localparam int CPF_CNT_W = 26;

    // Register port
    localparam int CPF_DEV_W = 7;
    localparam int CPF_REG_W = 8;
    localparam int CPF_DATA_W = 32;
    localparam logic [6:0] CPF_DEV_ADDR = 7'h76;
    localparam logic [7:0] CPF_REG_CTRL = 8'h00;
    localparam logic [7:0] CPF_REG_LIMIT = 8'h04;
    localparam logic [7:0] CPF_REG_VOUT = 8'h08;
    localparam logic [7:0] CPF_REG_STATUS = 8'h0C;
    localparam logic [7:0] CPF_REG_SHORT_RST = 8'h10;

    // Control register fields
    localparam int CPF_CTRL_W = 14;
    localparam logic [13:0] CPF_CTRL_RESET = 14'h0000;
    localparam int CPF_F_MODE = 0;
    localparam int CPF_F_FEEDBACK_SOURCE_SELECT = 2;
    localparam int CPF_F_UV_ENF = 3;
    localparam int CPF_F_SHORT_FILT = 4;
    localparam int CPF_F_AUTO_RTR = 5;
    localparam int CPF_F_SOFT_EN = 6;
    localparam int CPF_F_SOFT_LVL = 7;
    localparam int CPF_F_BOVP_ENF = 8;
    localparam int CPF_F_B_DIR = 9;
    localparam int CPF_F_C_DIR = 10;
    localparam int CPF_F_GATE_ON = 11;
    localparam int CPF_F_SHORT_RST = 0;

    // Limit and output voltage fields
    localparam int CPF_F_BAT_LIM = 8;
    localparam logic [9:0] CPF_LIMIT_RESET = 10'h000;
    localparam logic [9:0] CPF_VOUT_RESET = 10'h000;

    // Status register bit positions
    localparam int CPF_S_UV_B = 0;
    localparam int CPF_S_UV_C = 1;
    localparam int CPF_S_AG_B = 2;
    localparam int CPF_S_AG_C = 3;
    localparam int CPF_S_FB_SHORT = 4;
    localparam int CPF_S_BUS_SHORT = 5;
    localparam int CPF_S_BAT_OVP = 6;
    localparam int CPF_S_OTP = 7;
    localparam int CPF_S_OUT_OVP = 8;
    localparam int CPF_S_REG_BUS = 9;
    localparam int CPF_S_REG_BAT = 10;

    // Operating mode codes
    localparam logic [1:0] CPF_MODE_CHARGE = 2'h0;
    localparam logic [1:0] CPF_MODE_DISCHARGE = 2'h1;
    localparam logic [1:0] CPF_MODE_PASS = 2'h2;

    // Number of synchronised analog comparator inputs
    localparam int CPF_NCMP = 15;

    typedef enum logic [1:0] {SH_NORMAL, SH_OFF, SH_RETRY} cpf_short_type;
endpackage
`default_nettype wire

// ==== src/cpf_fault_manager.sv ====
// Contract
// - Over-limit bus or battery current is regulated at the limit.
// - A charging port below adapter-good threshold sets its undervolt flag.
// - Enforced undervolt clears adapter-good and forces that gate off at once.
// - After enforced undervolt clears, wait 20 ms before restoring both.
// - Unenforced undervolt only flags; adapter-good and operation unaffected.
// - Discharge over-voltage stops switching until clear; gates stay normal.
// - Over-voltage source follows feedback select: node or bus target+500mV.
// - Shorted external feedback in discharge uses internal setting, flags.
// - Bus below battery for 1 or 90 us in discharge/pass declares short.
// - On bus short switching continues but every port gate is forced off.
// - Auto-retry releases gates every 500 ms; clears short flag once gone.
// - Without auto-retry gates stay off until host writes short reset.
// - Enabled soft short: bus below 3.8/4.5 V over 8 ms acts as short.
// - Soft short disabled means no bus undervolt detection at all.
// - Battery above 103 percent of target sets battery overvolt flag.
// - Enforced battery overvolt stops switching, discharges, resumes below 101.
// - Unenforced battery overvolt only reports and keeps switching.
// - Above 165 C stop switching, set flag; below 150 C resume and clear.
// - Registers answer only at slave address 0x76.
//
// The strobed register port and the register addresses were decided locally.
`default_nettype none
module cpf_fault_manager
    import cpf_pkg::*;
#(
    parameter int unsigned HARD_LONG_CYCLES = cpf_pkg::CPF_HARD_LONG_CYC,
    parameter int unsigned SOFT_SHORT_CYCLES = cpf_pkg::CPF_SOFT_SHORT_CYC,
    parameter int unsigned UV_RECOVER_CYCLES = cpf_pkg::CPF_UV_RECOVER_CYC,
    parameter int unsigned RETRY_CYCLES = cpf_pkg::CPF_RETRY_CYC
)
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic [cpf_pkg::CPF_DEV_W-1:0] reg_dev,
    input wire logic [cpf_pkg::CPF_REG_W-1:0] reg_addr,
    input wire logic [cpf_pkg::CPF_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cpf_pkg::CPF_DATA_W-1:0] reg_rdata,
    // Analog comparator inputs
    input wire logic bus_over_limit,
    input wire logic bat_over_limit,
    input wire logic port_b_below_good,
    input wire logic port_c_below_good,
    input wire logic fb_over_ovp,
    input wire logic bus_over_target,
    input wire logic fb_shorted,
    input wire logic bus_below_bat,
    input wire logic bus_below_3v8,
    input wire logic bus_below_4v5,
    input wire logic bat_over_103,
    input wire logic bat_over_101,
    input wire logic temp_over_165,
    input wire logic temp_over_150,
    input wire logic spare_cmp,
    // Power stage controls
    output logic [7:0] bus_current_limit,
    output logic [1:0] battery_current_limit,
    output logic [9:0] output_voltage_setting,
    output logic regulate_bus,
    output logic regulate_bat,
    output logic switch_enable,
    output logic use_internal_feedback,
    output logic discharge_path_on,
    output logic [2:0] port_gate_driver
);
    import cpf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Saturating hold counter: counts while cond holds, else clears
    function automatic logic [CPF_CNT_W-1:0] hold_next(
        input logic [CPF_CNT_W-1:0] cnt,
        input logic cond,
        input logic [CPF_CNT_W-1:0] lim
    );
        logic [CPF_CNT_W-1:0] r;
        r = '0;
        if (cond)
        begin
            r = (cnt >= lim) ? lim : cnt + 1'b1;
        end
        return r;
    endfunction

    localparam logic [CPF_CNT_W-1:0] HARD_SHORT_LIM =
        CPF_CNT_W'(CPF_HARD_SHORT_CYC);
    localparam logic [CPF_CNT_W-1:0] HARD_LONG_LIM =
        CPF_CNT_W'(HARD_LONG_CYCLES);
    localparam logic [CPF_CNT_W-1:0] SOFT_LIM = CPF_CNT_W'(SOFT_SHORT_CYCLES);
    localparam logic [CPF_CNT_W-1:0] UV_LIM = CPF_CNT_W'(UV_RECOVER_CYCLES);
    localparam logic [CPF_CNT_W-1:0] RETRY_LIM = CPF_CNT_W'(RETRY_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [CPF_NCMP-1:0] cmp_raw;
    logic [CPF_NCMP-1:0] cmp_meta;
    logic [CPF_NCMP-1:0] cmp_s;

    assign cmp_raw = {spare_cmp, temp_over_150, temp_over_165, bat_over_101,
        bat_over_103, bus_below_4v5, bus_below_3v8, bus_below_bat,
        fb_shorted, bus_over_target, fb_over_ovp, port_c_below_good,
        port_b_below_good, bat_over_limit, bus_over_limit};

    // Two flip-flop synchroniser for all comparator levels
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_meta <= '0;
            cmp_s <= '0;
        end
        else if (clk_en)
        begin
            cmp_meta <= cmp_raw;
            cmp_s <= cmp_meta;
        end
    end

    logic s_bus_ilim, s_bat_ilim, s_b_low, s_c_low, s_fb_ovp, s_bus_ovp;
    logic s_fb_short, s_bus_lt_bat, s_lt_3v8, s_lt_4v5, s_bat_103;
    logic s_bat_101, s_t165, s_t150;

    assign s_bus_ilim = cmp_s[0];
    assign s_bat_ilim = cmp_s[1];
    assign s_b_low = cmp_s[2];
    assign s_c_low = cmp_s[3];
    assign s_fb_ovp = cmp_s[4];
    assign s_bus_ovp = cmp_s[5];
    assign s_fb_short = cmp_s[6];
    assign s_bus_lt_bat = cmp_s[7];
    assign s_lt_3v8 = cmp_s[8];
    assign s_lt_4v5 = cmp_s[9];
    assign s_bat_103 = cmp_s[10];
    assign s_bat_101 = cmp_s[11];
    assign s_t165 = cmp_s[12];
    assign s_t150 = cmp_s[13];

    ////////////////////////////////////////////////////////////////////////
    // Register port

    logic [CPF_CTRL_W-1:0] ctrl;
    logic [9:0] limits;
    logic short_reset_pulse;
    logic dev_hit;
    logic [CPF_DATA_W-1:0] status_word;

    assign dev_hit = (reg_dev == CPF_DEV_ADDR);

    // Writable configuration
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= CPF_CTRL_RESET;
            limits <= CPF_LIMIT_RESET;
            output_voltage_setting <= CPF_VOUT_RESET;
        end
        else if (clk_en && reg_wr && dev_hit)
        begin
            if (reg_addr == CPF_REG_CTRL)
                ctrl <= reg_wdata[CPF_CTRL_W-1:0];
            else if (reg_addr == CPF_REG_LIMIT)
                limits <= reg_wdata[9:0];
            else if (reg_addr == CPF_REG_VOUT)
                output_voltage_setting <= reg_wdata[9:0];
        end
    end

    // Short reset is a self-clearing write strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            short_reset_pulse <= 1'b0;
        else if (clk_en)
            short_reset_pulse <= reg_wr && dev_hit
                && reg_addr == CPF_REG_SHORT_RST
                && reg_wdata[CPF_F_SHORT_RST];
    end

    // Read data, valid only the cycle after the read strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (clk_en)
        begin
            reg_rdata <= '0;
            if (reg_rd && dev_hit)
            begin
                if (reg_addr == CPF_REG_CTRL)
                    reg_rdata <= {{(CPF_DATA_W-CPF_CTRL_W){1'b0}}, ctrl};
                else if (reg_addr == CPF_REG_LIMIT)
                    reg_rdata <= {22'h000000, limits};
                else if (reg_addr == CPF_REG_VOUT)
                    reg_rdata <= {22'h000000, output_voltage_setting};
                else if (reg_addr == CPF_REG_STATUS)
                    reg_rdata <= status_word;
            end
        end
    end

    // Control fields
    logic [1:0] mode;
    logic feedback_source_select, uv_enforce, short_filt, auto_retry, soft_en, soft_lvl;
    logic bovp_enforce, b_dir, c_dir;
    logic [2:0] gate_on;
    logic discharging, short_mode;

    assign mode = ctrl[CPF_F_MODE+:2];
    assign feedback_source_select = ctrl[CPF_F_FEEDBACK_SOURCE_SELECT];
    assign uv_enforce = ctrl[CPF_F_UV_ENF];
    assign short_filt = ctrl[CPF_F_SHORT_FILT];
    assign auto_retry = ctrl[CPF_F_AUTO_RTR];
    assign soft_en = ctrl[CPF_F_SOFT_EN];
    assign soft_lvl = ctrl[CPF_F_SOFT_LVL];
    assign bovp_enforce = ctrl[CPF_F_BOVP_ENF];
    assign b_dir = ctrl[CPF_F_B_DIR];
    assign c_dir = ctrl[CPF_F_C_DIR];
    assign gate_on = ctrl[CPF_F_GATE_ON+:3];
    assign discharging = (mode == CPF_MODE_DISCHARGE);
    assign short_mode = discharging || (mode == CPF_MODE_PASS);
    assign bus_current_limit = limits[7:0];
    assign battery_current_limit = limits[CPF_F_BAT_LIM+:2];

    ////////////////////////////////////////////////////////////////////////
    // Current limit: regulate, never shut down

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            regulate_bus <= 1'b0;
            regulate_bat <= 1'b0;
        end
        else if (clk_en)
        begin
            regulate_bus <= s_bus_ilim;
            regulate_bat <= s_bat_ilim;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input port undervoltage

    logic [1:0] uv_flag;
    logic [1:0] uv_hit;
    logic [1:0] adapter_good;
    logic [CPF_CNT_W-1:0] uv_cnt [2];

    // Port B charges when its direction bit is 0, port C likewise
    assign uv_flag = {~c_dir & s_c_low, ~b_dir & s_b_low};
    assign uv_hit = uv_flag & {2{uv_enforce}};

    // Adapter-good drops at once and returns after the recovery delay
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            adapter_good <= 2'b11;
            uv_cnt[0] <= '0;
            uv_cnt[1] <= '0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < 2; i++)
            begin
                uv_cnt[i] <= hold_next(uv_cnt[i], !adapter_good[i], UV_LIM);
                if (uv_hit[i])
                begin
                    adapter_good[i] <= 1'b0;
                    uv_cnt[i] <= '0;
                end
                else if (!adapter_good[i] && uv_cnt[i] >= UV_LIM - 1'b1)
                    adapter_good[i] <= 1'b1;
                else if (!uv_enforce)
                    adapter_good[i] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Feedback short and output over-voltage

    logic fb_short_flag;
    logic out_ovp;

    assign fb_short_flag = discharging && feedback_source_select && s_fb_short;
    // External node is judged only while it is usable
    assign out_ovp = discharging && ((feedback_source_select && !fb_short_flag)
        ? s_fb_ovp : s_bus_ovp);

    ////////////////////////////////////////////////////////////////////////
    // Bus short detection and recovery

    logic [CPF_CNT_W-1:0] hard_cnt, soft_cnt, retry_cnt, hard_lim;
    logic soft_low, raw_short, short_detect;
    cpf_short_type sh_state;

    assign hard_lim = short_filt ? HARD_LONG_LIM : HARD_SHORT_LIM;
    assign soft_low = soft_lvl ? s_lt_4v5 : s_lt_3v8;
    assign raw_short = short_mode && (s_bus_lt_bat || (soft_en && soft_low));
    assign short_detect = (hard_cnt >= hard_lim) || (soft_cnt >= SOFT_LIM);

    // Filters: hard short time and soft short time
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            hard_cnt <= '0;
            soft_cnt <= '0;
        end
        else if (clk_en)
        begin
            hard_cnt <= hold_next(hard_cnt, short_mode && s_bus_lt_bat,
                hard_lim);
            soft_cnt <= hold_next(soft_cnt,
                short_mode && soft_en && soft_low, SOFT_LIM);
        end
    end

    // Hiccup or latched recovery
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sh_state <= SH_NORMAL;
            retry_cnt <= '0;
        end
        else if (clk_en)
        begin
            case (sh_state)
                SH_NORMAL:
                begin
                    retry_cnt <= '0;
                    if (short_detect)
                        sh_state <= SH_OFF;
                end
                SH_OFF:
                begin
                    if (auto_retry)
                    begin
                        retry_cnt <= retry_cnt + 1'b1;
                        if (retry_cnt >= RETRY_LIM - 1'b1)
                            sh_state <= SH_RETRY;
                    end
                    else if (short_reset_pulse)
                        sh_state <= SH_RETRY;
                end
                SH_RETRY:
                begin
                    retry_cnt <= '0;
                    if (short_detect)
                        sh_state <= SH_OFF;
                    else if (!raw_short)
                        sh_state <= SH_NORMAL;
                end
                default: sh_state <= SH_NORMAL;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Battery over-voltage and thermal shutdown

    logic bovp_hold, otp_flag;

    // Hysteresis between the 103 and 101 percent comparators
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bovp_hold <= 1'b0;
            otp_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (bovp_enforce && s_bat_103)
                bovp_hold <= 1'b1;
            else if (!bovp_enforce || !s_bat_101)
                bovp_hold <= 1'b0;
            if (s_t165)
                otp_flag <= 1'b1;
            else if (!s_t150)
                otp_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power stage outputs

    logic [2:0] gate_block;

    // Port A is index 0, port B 1, port C 2
    assign gate_block = (sh_state == SH_OFF) ? 3'h7
        : {~adapter_good[1], ~adapter_good[0], 1'b0};

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            port_gate_driver <= 3'h0;
            switch_enable <= 1'b0;
            use_internal_feedback <= 1'b1;
            discharge_path_on <= 1'b0;
        end
        else if (clk_en)
        begin
            port_gate_driver <= gate_on & ~gate_block;
            // Short keeps switching; only these three stop it
            switch_enable <= !out_ovp && !bovp_hold
                && !otp_flag;
            use_internal_feedback <= !feedback_source_select || fb_short_flag;
            discharge_path_on <= bovp_hold;
        end
    end

    // Status word
    always_comb
    begin
        status_word = '0;
        status_word[CPF_S_UV_B] = uv_flag[0];
        status_word[CPF_S_UV_C] = uv_flag[1];
        status_word[CPF_S_AG_B] = adapter_good[0];
        status_word[CPF_S_AG_C] = adapter_good[1];
        status_word[CPF_S_FB_SHORT] = fb_short_flag;
        status_word[CPF_S_BUS_SHORT] = (sh_state != SH_NORMAL);
        status_word[CPF_S_BAT_OVP] = s_bat_103;
        status_word[CPF_S_OTP] = otp_flag;
        status_word[CPF_S_OUT_OVP] = out_ovp;
        status_word[CPF_S_REG_BUS] = regulate_bus;
        status_word[CPF_S_REG_BAT] = regulate_bat;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk iff clk_en);
    endclocking
    default disable iff (rst);

    property p_uv_gate_off;
        uv_hit[0] |=> !adapter_good[0] ##1 !port_gate_driver[1];
    endproperty
    a_uv_gate_off: assert property (p_uv_gate_off)
        else $error("undervolt did not force port gate off");

    property p_uv_delay;
        !adapter_good[0] && $fell(uv_hit[0]) && uv_enforce
            |-> !adapter_good[0] [*8];
    endproperty
    a_uv_delay: assert property (p_uv_delay)
        else $error("adapter good restored before recovery delay");

    property p_uv_passive;
        !uv_enforce |=> adapter_good == 2'b11;
    endproperty
    a_uv_passive: assert property (p_uv_passive)
        else $error("adapter good touched with enforce off");

    property p_ovp_stop;
        out_ovp |=> !switch_enable;
    endproperty
    a_ovp_stop: assert property (p_ovp_stop)
        else $error("switching continued during output over-voltage");

    property p_short_detect;
        short_mode && s_bus_lt_bat && hard_cnt == hard_lim - 1'b1
            && sh_state == SH_NORMAL |=> ##1 sh_state == SH_OFF;
    endproperty
    a_short_detect: assert property (p_short_detect)
        else $error("hard short not declared after filter time");

    property p_short_gates;
        sh_state == SH_OFF |=> port_gate_driver == 3'h0;
    endproperty
    a_short_gates: assert property (p_short_gates)
        else $error("gate driven during bus short");

    property p_latched;
        sh_state == SH_OFF && !auto_retry && !short_reset_pulse
            |=> sh_state == SH_OFF;
    endproperty
    a_latched: assert property (p_latched)
        else $error("latched short left without host reset");

    property p_soft_off;
        !soft_en |=> soft_cnt == '0;
    endproperty
    a_soft_off: assert property (p_soft_off)
        else $error("soft short counted while disabled");

    property p_bovp;
        bovp_enforce && s_bat_103 |=> ##1 !switch_enable && discharge_path_on;
    endproperty
    a_bovp: assert property (p_bovp)
        else $error("battery overvolt did not stop switching");

    property p_otp;
        s_t165 |=> otp_flag ##1 !switch_enable;
    endproperty
    a_otp: assert property (p_otp)
        else $error("thermal shutdown not taken");

    c_short_retry: cover property (sh_state == SH_OFF
        ##1 sh_state == SH_RETRY);
    c_short_clear: cover property (sh_state == SH_RETRY
        ##1 sh_state == SH_NORMAL);
    c_uv_recover: cover property ($rose(adapter_good[1]));
    c_bovp: cover property ($fell(bovp_hold));
endmodule
`default_nettype wire

// ==== bench/cpf_host_model.sv ====
`default_nettype none
module cpf_host_model
    import cpf_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Register port
    output logic [cpf_pkg::CPF_DEV_W-1:0] reg_dev,
    output logic [cpf_pkg::CPF_REG_W-1:0] reg_addr,
    output logic [cpf_pkg::CPF_DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [cpf_pkg::CPF_DATA_W-1:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial
    begin
        reg_dev = CPF_DEV_ADDR;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; VOUT is never written, so it stays zero
    task automatic wr(input logic [6:0] dv, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge core_clk);
        reg_dev <= dv;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [6:0] dv, input logic [7:0] a,
                      output logic [31:0] d);
        @(posedge core_clk);
        reg_dev <= dv;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top;
    import cpf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [14:0] cmp = 15'h0000;
    logic [6:0] dv;
    logic [7:0] a;
    logic [31:0] wd, rdat, d;
    logic wr, rd, sw, dis, fbi, rbus, rbat;
    logic [2:0] gate;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, timeout
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            summarize();
        end
    end
    cpf_host_model host (.core_clk(core_clk), .reg_dev(dv), .reg_addr(a),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
    cpf_fault_manager #(.HARD_LONG_CYCLES(50), .SOFT_SHORT_CYCLES(40),
        .UV_RECOVER_CYCLES(30), .RETRY_CYCLES(60)) dut (
        .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .reg_dev(dv),
        .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdat), .bus_over_limit(cmp[0]), .bat_over_limit(cmp[1]),
        .port_b_below_good(cmp[2]), .port_c_below_good(cmp[3]),
        .fb_over_ovp(cmp[4]), .bus_over_target(cmp[5]),
        .fb_shorted(cmp[6]), .bus_below_bat(cmp[7]),
        .bus_below_3v8(cmp[8]), .bus_below_4v5(cmp[9]),
        .bat_over_103(cmp[10]), .bat_over_101(cmp[11]),
        .temp_over_165(cmp[12]), .temp_over_150(cmp[13]),
        .spare_cmp(cmp[14]), .bus_current_limit(),
        .battery_current_limit(), .output_voltage_setting(),
        .regulate_bus(rbus), .regulate_bat(rbat), .switch_enable(sw),
        .use_internal_feedback(fbi), .discharge_path_on(dis),
        .port_gate_driver(gate));
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial
    begin
        w(10);
        rst <= 1'b0;
        host.rd(CPF_DEV_ADDR, CPF_REG_CTRL, d);
        chk("ctrl_rst", 32'h0, d);
        // Charge, undervolt enforced, all gates on
        host.wr(CPF_DEV_ADDR, CPF_REG_CTRL, 32'h3808);
        host.wr(7'h75, CPF_REG_CTRL, 32'h0000);
        host.rd(7'h75, CPF_REG_CTRL, d);
        chk("wrong_dev", 32'h0, d);
        host.rd(CPF_DEV_ADDR, CPF_REG_CTRL, d);
        chk("ctrl", 32'h3808, d);
        host.rd(CPF_DEV_ADDR, 8'h14, d);
        chk("unmapped", 32'h0, d);
        cmp[2] <= 1'b1;
        w(5);
        chk("gate_uv", 32'h5, gate);
        host.rd(CPF_DEV_ADDR, CPF_REG_STATUS, d);
        chk("stat_uv", 32'h9, d & 32'hF);
        cmp[2] <= 1'b0;
        w(10);
        chk("gate_hold", 32'h5, gate);
        w(30);
        chk("gate_back", 32'h7, gate);
        // Pass, 1us filter, latched short
        host.wr(CPF_DEV_ADDR, CPF_REG_CTRL, 32'h3802);
        cmp[7] <= 1'b1;
        w(90);
        chk("gate_early", 32'h7, gate);
        w(30);
        chk("gate_short", 32'h0, gate);
        chk("sw_short", 32'h1, sw);
        host.rd(CPF_DEV_ADDR, CPF_REG_STATUS, d);
        chk("stat_short", 32'h20, d & 32'h20);
        cmp[7] <= 1'b0;
        w(20);
        chk("gate_latch", 32'h0, gate);
        host.wr(CPF_DEV_ADDR, CPF_REG_SHORT_RST, 32'h1);
        w(5);
        chk("gate_rst", 32'h7, gate);
        // Battery overvolt enforced
        host.wr(CPF_DEV_ADDR, CPF_REG_CTRL, 32'h3901);
        cmp[11:10] <= 2'b11;
        w(5);
        chk("sw_bovp", 32'h0, sw);
        chk("dis_bovp", 32'h1, dis);
        chk("gate_bovp", 32'h7, gate);
        cmp[11:10] <= 2'b00;
        // Over-temperature with hysteresis
        cmp[13:12] <= 2'b11;
        w(5);
        chk("sw_otp", 32'h0, sw);
        cmp[12] <= 1'b0;
        w(5);
        chk("sw_hyst", 32'h0, sw);
        cmp[13] <= 1'b0;
        w(5);
        chk("sw_cool", 32'h1, sw);
        // Current limit, external feedback, its short and output OVP
        cmp[1:0] <= 2'b11;
        cmp[4] <= 1'b1;
        host.wr(CPF_DEV_ADDR, CPF_REG_CTRL, 32'h3805);
        w(5);
        chk("rbus", 32'h1, rbus);
        chk("rbat", 32'h1, rbat);
        chk("fbi_ext", 32'h0, fbi);
        chk("sw_fbovp", 32'h0, sw);
        cmp[6] <= 1'b1;
        w(5);
        chk("fbi_short", 32'h1, fbi);
        chk("sw_busovp", 32'h1, sw);
        host.rd(CPF_DEV_ADDR, CPF_REG_STATUS, d);
        chk("stat_fbsc", 32'h10, d & 32'h10);
        cmp[6] <= 1'b0;
        w(5);
        chk("fbi_back", 32'h0, fbi);
        chk("sw_fbovp2", 32'h0, sw);
        cmp[4] <= 1'b0;
        cmp[1:0] <= 2'b00;
        cmp[10] <= 1'b1;
        w(5);
        chk("sw_bovp_off", 32'h1, sw);
        host.rd(CPF_DEV_ADDR, CPF_REG_STATUS, d);
        chk("stat_bovp", 32'h40, d & 32'h40);
        // Soft short with hiccup retry
        cmp[10] <= 1'b0;
        cmp[8] <= 1'b1;
        host.wr(CPF_DEV_ADDR, CPF_REG_CTRL, 32'h3861);
        w(30);
        chk("gate_soft_early", 32'h7, gate);
        w(20);
        chk("gate_soft", 32'h0, gate);
        w(60);
        chk("gate_rehit", 32'h0, gate);
        cmp[8] <= 1'b0;
        w(40);
        chk("gate_interval", 32'h0, gate);
        w(20);
        chk("gate_retry", 32'h7, gate);
        host.rd(CPF_DEV_ADDR, CPF_REG_STATUS, d);
        chk("stat_clear", 32'h0, d & 32'h20);
        summarize();
    end
endmodule
`default_nettype wire
